// [hdl/pmscr_pkg.sv]
// ==========================================================
// shared constants and carriers for the status/config bank
package pmscr_pkg;

  // ==========================================================
  // widths
  localparam int PTR_W    = 16;
  localparam int DATA_W   = 32;
  localparam int STAT_W   = 16;
  localparam int GAIN_W   = 3;
  localparam int SHIFT_W  = 3;
  localparam int SAMPLE_W = 24;
  localparam int TRIM_W   = 8;

  // ==========================================================
  // register offsets (byte addresses held in the pointer)
  localparam logic [PTR_W-1:0] OFS_SYSTEM_FLAGS     = 16'h0002;
  localparam logic [PTR_W-1:0] OFS_ENGINE_DATE_CODE = 16'h0004;
  localparam logic [PTR_W-1:0] OFS_SYSTEM_CONFIG    = 16'h00a0;

  // ==========================================================
  // system_flags bit positions
  localparam int FLG_MAINS_FAIL   = 12;
  localparam int FLG_DET_B        = 11;
  localparam int FLG_DET_A        = 10;
  localparam int FLG_CH2_POWER    = 9;
  localparam int FLG_CH2_CURRENT  = 8;
  localparam int FLG_CH2_REACTIVE = 7;
  localparam int FLG_CH2_ACTIVE   = 6;
  localparam int FLG_CH1_REACTIVE = 5;
  localparam int FLG_CH1_ACTIVE   = 4;
  localparam int FLG_CH1_POWER    = 3;
  localparam int FLG_CH1_CURRENT  = 2;
  localparam int FLG_V_HIGH       = 1;
  localparam int FLG_V_LOW        = 0;
  localparam int FLG_UNUSED_LO    = 13;

  // ==========================================================
  // system_config field positions
  localparam int CFG_GAIN_CH1_LSB = 0;
  localparam int CFG_GAIN_CH2_LSB = 3;
  localparam int CFG_SOFT_RST_LSB = 6;
  localparam int CFG_SHUTDOWN_LSB = 8;
  localparam int CFG_TRIM_LSB     = 16;

  // ==========================================================
  // reset values
  localparam logic [PTR_W-1:0]  PTR_RST       = 16'h0000;
  localparam logic [GAIN_W-1:0] GAIN_RST      = 3'h0;
  localparam logic [1:0]        SOFT_RST_RST  = 2'h0;
  localparam logic [1:0]        SHUTDOWN_RST  = 2'h0;
  localparam logic [TRIM_W-1:0] TRIM_RST      = 8'h42;
  localparam logic [SHIFT_W-1:0] SHIFT_UNITY  = 3'h0;

  // latched flag indices inside the sticky vector
  localparam int LAT_V_LOW  = 0;
  localparam int LAT_V_HIGH = 1;
  localparam int LAT_DET_A  = 2;
  localparam int LAT_DET_B  = 3;

  // measurement results refreshed at each computation end
  typedef struct packed {
    logic mains_detect_fail;
    logic ch2_power_limit_hit;
    logic ch2_current_limit_hit;
    logic ch2_reactive_sign;
    logic ch2_active_sign;
    logic ch1_reactive_sign;
    logic ch1_active_sign;
    logic ch1_power_limit_hit;
    logic ch1_current_limit_hit;
  } pmscr_meas_t;

  // one-cycle event pulses for the latched flags
  typedef struct packed {
    logic detector_b;
    logic detector_a;
    logic voltage_high;
    logic voltage_low;
  } pmscr_event_t;

endpackage : pmscr_pkg

// [hdl/pmscr_gain_dec.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// gain code to left-shift amount (gain = 2**shift)
module pmscr_gain_dec
  import pmscr_pkg::*;
(
  input  wire logic [pmscr_pkg::GAIN_W-1:0]  code_i,
  output logic      [pmscr_pkg::SHIFT_W-1:0] shift_o
);

  // codes 0..5 map to x1..x32, undefined codes fall back to unity
  always_comb begin
    unique case (code_i)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: shift_o = code_i;
      default:                            shift_o = SHIFT_UNITY;
    endcase
  end

endmodule : pmscr_gain_dec
`default_nettype wire

// [hdl/pmscr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module pmscr_regs
  import pmscr_pkg::*;
#(
  // date code value is arbitrary
  parameter logic [pmscr_pkg::STAT_W-1:0] DATE_CODE = 16'h0a15
) (
  input  wire logic                               clk_i,
  input  wire logic                               resetn_i,
  // command port from the serial command decoder
  input  wire logic                               set_ptr_i,
  input  wire logic [pmscr_pkg::PTR_W-1:0]        set_ptr_addr_i,
  input  wire logic                               wr_en_i,
  input  wire logic [pmscr_pkg::DATA_W-1:0]       wr_data_i,
  input  wire logic                               rd_en_i,
  output logic      [pmscr_pkg::DATA_W-1:0]       rd_data_o,
  output logic                                    rd_valid_o,
  output logic      [pmscr_pkg::PTR_W-1:0]        pointer_o,
  // measurement engine
  input  wire logic                               compute_done_i,
  input  wire pmscr_pkg::pmscr_meas_t             meas_i,
  input  wire pmscr_pkg::pmscr_event_t            event_i,
  input  wire pmscr_pkg::pmscr_event_t            event_clear_i,
  // converter datapath
  input  wire logic [pmscr_pkg::SAMPLE_W-1:0]     ch1_sample_i,
  input  wire logic [pmscr_pkg::SAMPLE_W-1:0]     ch2_sample_i,
  output logic      [pmscr_pkg::SAMPLE_W-1:0]     ch1_sample_o,
  output logic      [pmscr_pkg::SAMPLE_W-1:0]     ch2_sample_o,
  output logic      [1:0]                         converter_enable_o,
  output logic      [pmscr_pkg::SHIFT_W-1:0]      ch1_gain_shift_o,
  output logic      [pmscr_pkg::SHIFT_W-1:0]      ch2_gain_shift_o,
  output logic      [pmscr_pkg::TRIM_W-1:0]       reference_trim_code_o
);
  import pmscr_pkg::*;

  // ==========================================================
  // state
  logic [PTR_W-1:0]   register_pointer_reg;
  pmscr_meas_t        meas_reg;
  logic [3:0]         latched_reg;
  logic [3:0]         latched_next;
  logic [GAIN_W-1:0]  ch1_gain_code_reg;
  logic [GAIN_W-1:0]  ch2_gain_code_reg;
  logic [1:0]         soft_reset_reg;
  logic [1:0]         shutdown_reg;
  logic [TRIM_W-1:0]  trim_reg;
  logic [STAT_W-1:0]  system_flags;
  logic [DATA_W-1:0]  system_config;
  logic [DATA_W-1:0]  rd_mux;
  logic [SHIFT_W-1:0] ch1_shift;
  logic [SHIFT_W-1:0] ch2_shift;
  logic               cfg_wr;

  // ==========================================================
  // address pointer
  // only the set-pointer command moves the pointer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      register_pointer_reg <= PTR_RST;
    end else if (set_ptr_i) begin
      register_pointer_reg <= set_ptr_addr_i;
    end
  end

  // writes land only where the pointer selects the config word
  assign cfg_wr = wr_en_i && (register_pointer_reg == OFS_SYSTEM_CONFIG);

  // ==========================================================
  // status flags
  // live results sampled at the end of each computation
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meas_reg <= '0;
    end else if (compute_done_i) begin
      meas_reg <= meas_i;
    end
  end

  // sticky flags: a new event beats a clear in the same cycle
  always_comb begin
    latched_next             = latched_reg & ~{event_clear_i.detector_b, event_clear_i.detector_a,
                                               event_clear_i.voltage_high,
                                               event_clear_i.voltage_low};
    latched_next[LAT_V_LOW]  = latched_next[LAT_V_LOW]  | event_i.voltage_low;
    latched_next[LAT_V_HIGH] = latched_next[LAT_V_HIGH] | event_i.voltage_high;
    latched_next[LAT_DET_A]  = latched_next[LAT_DET_A]  | event_i.detector_a;
    latched_next[LAT_DET_B]  = latched_next[LAT_DET_B]  | event_i.detector_b;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      latched_reg <= 4'h0;
    end else begin
      latched_reg <= latched_next;
    end
  end

  // status word assembly, top bits unimplemented
  always_comb begin
    system_flags                   = 16'h0000;
    system_flags[FLG_MAINS_FAIL]   = meas_reg.mains_detect_fail;
    system_flags[FLG_DET_B]        = latched_reg[LAT_DET_B];
    system_flags[FLG_DET_A]        = latched_reg[LAT_DET_A];
    system_flags[FLG_CH2_POWER]    = meas_reg.ch2_power_limit_hit;
    system_flags[FLG_CH1_POWER]    = meas_reg.ch1_power_limit_hit;
    system_flags[FLG_CH2_CURRENT]  = meas_reg.ch2_current_limit_hit;
    system_flags[FLG_CH1_CURRENT]  = meas_reg.ch1_current_limit_hit;
    system_flags[FLG_CH2_REACTIVE] = meas_reg.ch2_reactive_sign;
    system_flags[FLG_CH1_REACTIVE] = meas_reg.ch1_reactive_sign;
    system_flags[FLG_CH2_ACTIVE]   = meas_reg.ch2_active_sign;
    system_flags[FLG_CH1_ACTIVE]   = meas_reg.ch1_active_sign;
    system_flags[FLG_V_HIGH]       = latched_reg[LAT_V_HIGH];
    system_flags[FLG_V_LOW]        = latched_reg[LAT_V_LOW];
  end

  // ==========================================================
  // configuration word
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ch1_gain_code_reg <= GAIN_RST;
      ch2_gain_code_reg <= GAIN_RST;
      soft_reset_reg    <= SOFT_RST_RST;
      shutdown_reg      <= SHUTDOWN_RST;
      trim_reg          <= TRIM_RST;
    end else if (cfg_wr) begin
      ch1_gain_code_reg <= wr_data_i[CFG_GAIN_CH1_LSB +: GAIN_W];
      ch2_gain_code_reg <= wr_data_i[CFG_GAIN_CH2_LSB +: GAIN_W];
      soft_reset_reg    <= wr_data_i[CFG_SOFT_RST_LSB +: 2];
      shutdown_reg      <= wr_data_i[CFG_SHUTDOWN_LSB +: 2];
      trim_reg          <= wr_data_i[CFG_TRIM_LSB +: TRIM_W];
    end
  end

  // readback image of the config word
  always_comb begin
    system_config                                = '0;
    system_config[CFG_GAIN_CH1_LSB +: GAIN_W]    = ch1_gain_code_reg;
    system_config[CFG_GAIN_CH2_LSB +: GAIN_W]    = ch2_gain_code_reg;
    system_config[CFG_SOFT_RST_LSB +: 2]         = soft_reset_reg;
    system_config[CFG_SHUTDOWN_LSB +: 2]         = shutdown_reg;
    system_config[CFG_TRIM_LSB +: TRIM_W]        = trim_reg;
  end

  // ==========================================================
  // gain decode, one per channel
  pmscr_gain_dec u_gain_ch1 (
    .code_i  (ch1_gain_code_reg),
    .shift_o (ch1_shift)
  );

  pmscr_gain_dec u_gain_ch2 (
    .code_i  (ch2_gain_code_reg),
    .shift_o (ch2_shift)
  );

  // ==========================================================
  // converter controls
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ch1_gain_shift_o      <= SHIFT_UNITY;
      ch2_gain_shift_o      <= SHIFT_UNITY;
      converter_enable_o    <= 2'h3;
      reference_trim_code_o <= TRIM_RST;
    end else begin
      ch1_gain_shift_o      <= ch1_shift;
      ch2_gain_shift_o      <= ch2_shift;
      converter_enable_o    <= ~shutdown_reg;
      reference_trim_code_o <= trim_reg;
    end
  end

  // converters keep running under soft reset, output held at zero
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ch1_sample_o <= '0;
      ch2_sample_o <= '0;
    end else begin
      ch1_sample_o <= soft_reset_reg[0] ? '0 : ch1_sample_i;
      ch2_sample_o <= soft_reset_reg[1] ? '0 : ch2_sample_i;
    end
  end

  // ==========================================================
  // read path
  // unmapped locations read as zero
  always_comb begin
    unique case (register_pointer_reg)
      OFS_SYSTEM_FLAGS:     rd_mux = {16'h0000, system_flags};
      OFS_ENGINE_DATE_CODE: rd_mux = {16'h0000, DATE_CODE};
      OFS_SYSTEM_CONFIG:    rd_mux = system_config;
      default:              rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pointer_o <= PTR_RST;
    end else begin
      pointer_o <= register_pointer_reg;
    end
  end

  // ==========================================================
  // checks
  sequence s_set_ptr;
    set_ptr_i;
  endsequence

  sequence s_cfg_write;
    wr_en_i && (register_pointer_reg == OFS_SYSTEM_CONFIG);
  endsequence

  a_ptr_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_set_ptr |=> register_pointer_reg == $past(set_ptr_addr_i))
    else $error("pointer did not load the command address");

  a_ptr_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !set_ptr_i |=> $stable(register_pointer_reg))
    else $error("pointer moved without set-pointer command");

  a_status_top: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_en_i && register_pointer_reg == OFS_SYSTEM_FLAGS |=> rd_valid_o && rd_data_o[31:13] == '0)
    else $error("status upper bits not zero");

  a_sticky_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    latched_reg[LAT_DET_B] && !event_clear_i.detector_b |=> latched_reg[LAT_DET_B])
    else $error("detector b flag dropped without clear");

  a_set_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
    event_i.voltage_high |=> system_flags[FLG_V_HIGH] [*1] ##0 latched_reg[LAT_V_HIGH])
    else $error("surge event lost");

  a_sag_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
    event_i.voltage_low ##1 !event_clear_i.voltage_low |-> ##1 system_flags[FLG_V_LOW])
    else $error("sag flag not held");

  a_live_refresh: assert property (@(posedge clk_i) disable iff (!resetn_i)
    compute_done_i |=> system_flags[FLG_MAINS_FAIL] == $past(meas_i.mains_detect_fail)
                       && system_flags[FLG_CH1_POWER] == $past(meas_i.ch1_power_limit_hit))
    else $error("live status not refreshed");

  a_live_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !compute_done_i |=> $stable(meas_reg))
    else $error("live status changed between computations");

  a_date_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_en_i && register_pointer_reg == OFS_ENGINE_DATE_CODE |=> rd_data_o == {16'h0000, DATE_CODE})
    else $error("date code read wrong");

  a_gain_undef: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ch1_gain_code_reg[2:1] == 2'b11 |=> ch1_gain_shift_o == SHIFT_UNITY)
    else $error("undefined gain code not unity");

  a_gain_map: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ch2_gain_code_reg == 3'h5 |=> ch2_gain_shift_o == 3'h5)
    else $error("gain code five not x32");

  a_soft_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    soft_reset_reg[0] |=> ch1_sample_o == '0)
    else $error("soft reset did not zero output");

  a_shutdown: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_cfg_write ##1 1'b1 |=> converter_enable_o == ~$past(wr_data_i[CFG_SHUTDOWN_LSB +: 2], 2))
    else $error("shutdown bits not applied");

  a_wakeup: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(shutdown_reg[1]) |=> converter_enable_o[1])
    else $error("converter not re-enabled");

  a_trim_reset: assert property (@(posedge clk_i)
    !resetn_i |=> trim_reg == TRIM_RST)
    else $error("trim reset value wrong");

  a_cfg_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_cfg_write |=> system_config == ($past(wr_data_i) & 32'h00ff03ff))
    else $error("config write not stored");

endmodule : pmscr_regs
`default_nettype wire

// [dv/pmscr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side: issues set-pointer, write and read commands
module pmscr_host_model
  import pmscr_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic                         rd_valid_i,
  input  wire logic [pmscr_pkg::DATA_W-1:0] rd_data_i,
  output var logic                          set_ptr_o,
  output var logic  [pmscr_pkg::PTR_W-1:0]  set_ptr_addr_o,
  output var logic                          wr_en_o,
  output var logic  [pmscr_pkg::DATA_W-1:0] wr_data_o,
  output var logic                          rd_en_o
);
  // idle command lines at time zero
  initial begin
    set_ptr_o      = 1'b0;
    set_ptr_addr_o = '0;
    wr_en_o        = 1'b0;
    wr_data_o      = '0;
    rd_en_o        = 1'b0;
  end

  // ==========================================================
  // pointer moves only through this command; released lines invert
  task automatic set_pointer(input logic [PTR_W-1:0] addr);
    @(posedge clk_i);
    set_ptr_o      <= 1'b1;
    set_ptr_addr_o <= addr;
    @(posedge clk_i);
    set_ptr_o      <= 1'b0;
    set_ptr_addr_o <= ~addr;
  endtask : set_pointer

  // write one whole word to the current pointer
  task automatic write_word(input logic [DATA_W-1:0] data);
    @(posedge clk_i);
    wr_en_o   <= 1'b1;
    wr_data_o <= data;
    @(posedge clk_i);
    wr_en_o   <= 1'b0;
    wr_data_o <= ~data;
  endtask : write_word

  // read one word, bounded wait for the answer pulse
  task automatic read_word(output logic [DATA_W-1:0] data, output logic ok);
    int n;
    ok   = 1'b0;
    data = '0;
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (rd_valid_i === 1'b1) begin
        data = rd_data_i;
        ok   = 1'b1;
      end else begin
        @(posedge clk_i);
      end
    end
  endtask : read_word
endmodule : pmscr_host_model
`default_nettype wire

// [dv/tb_power_monitor_status_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the status/config bank
module tb_power_monitor_status_config_regs;
  import pmscr_pkg::*;
  localparam logic [15:0] DATE_TB = 16'h3c07; // arbitrary date code
  logic              clk_i = 1'b0;
  logic              resetn_i = 1'b0;
  logic              set_ptr, wr_en, rd_en, rd_valid, compute_done;
  logic [15:0]       set_ptr_addr, pointer;
  logic [31:0]       wr_data, rd_data, rd, cfg, rnd;
  logic [23:0]       ch1_in, ch2_in, ch1_out, ch2_out;
  logic [2:0]        g1, g2;
  logic [1:0]        conv_en;
  logic [7:0]        trim;
  logic [3:0]        sticky, ev, clr;
  logic              ok;
  pmscr_meas_t       meas, m;
  pmscr_event_t      event_s, event_clr;
  int                num_errors = 0;
  int                checks = 0;

  always #2 clk_i = ~clk_i;

  pmscr_regs #(.DATE_CODE(DATE_TB)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .set_ptr_i(set_ptr), .set_ptr_addr_i(set_ptr_addr),
    .wr_en_i(wr_en), .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .pointer_o(pointer), .compute_done_i(compute_done),
    .meas_i(meas), .event_i(event_s), .event_clear_i(event_clr), .ch1_sample_i(ch1_in),
    .ch2_sample_i(ch2_in), .ch1_sample_o(ch1_out), .ch2_sample_o(ch2_out),
    .converter_enable_o(conv_en), .ch1_gain_shift_o(g1), .ch2_gain_shift_o(g2),
    .reference_trim_code_o(trim));

  pmscr_host_model host (
    .clk_i(clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .set_ptr_o(set_ptr),
    .set_ptr_addr_o(set_ptr_addr), .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en));

  // ==========================================================
  // expectations
  function automatic logic [2:0] exp_shift(input logic [2:0] code);
    return (code < 3'h6) ? code : 3'h0;
  endfunction : exp_shift

  function automatic logic [31:0] exp_status(input pmscr_meas_t mv, input logic [3:0] s);
    logic [31:0] r;
    r     = '0;
    r[12] = mv.mains_detect_fail;
    r[11] = s[3];
    r[10] = s[2];
    r[9]  = mv.ch2_power_limit_hit;
    r[8]  = mv.ch2_current_limit_hit;
    r[7]  = mv.ch2_reactive_sign;
    r[6]  = mv.ch2_active_sign;
    r[5]  = mv.ch1_reactive_sign;
    r[4]  = mv.ch1_active_sign;
    r[3]  = mv.ch1_power_limit_hit;
    r[2]  = mv.ch1_current_limit_hit;
    r[1]  = s[1];
    r[0]  = s[0];
    return r;
  endfunction : exp_status

  // ==========================================================
  // compare, read and verdict helpers
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check_val

  task automatic tally_and_finish();
    $display("counts: %0d checks, %0d errors", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_read(output logic [31:0] d);
    host.read_word(d, ok);
    if (!ok) begin
      num_errors++;
      $display("wrong value at %0t: read answer missing", $time);
      tally_and_finish();
    end
  endtask : do_read

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(29));
    // idle measurement side; later scenarios drive these with random values, except compute_done, which gets one-cycle pulses
    compute_done = 1'b0;
    ch1_in       = '0;
    ch2_in       = '0;
    meas         = '0;
    event_s      = '0;
    event_clr    = '0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    // reset values
    host.set_pointer(16'h00a0);
    do_read(rd);
    check_val(rd, 32'h0042_0000, "config reset");
    check_val({24'h0, trim}, 32'h42, "trim reset");
    check_val({30'h0, conv_en}, 32'h3, "enable reset");
    check_val({16'h0, pointer}, 32'h00a0, "pointer");
    $display("test reset values done");
    // date code, refused write, unmapped read, status after reset
    host.set_pointer(16'h0004);
    host.write_word(32'hffff_ffff);
    do_read(rd);
    check_val(rd, {16'h0, DATE_TB}, "date code");
    check_val({16'h0, pointer}, 32'h0004, "pointer kept");
    host.set_pointer(16'h0006);
    do_read(rd);
    check_val(rd, 32'h0, "unmapped");
    host.set_pointer(16'h0002);
    host.write_word(32'hffff_ffff);
    do_read(rd);
    check_val(rd, 32'h0, "status reset");
    host.set_pointer(16'h00a0);
    do_read(rd);
    check_val(rd, 32'h0042_0000, "config untouched");
    $display("test pointer targeting done");
    // every gain code with random soft reset, shutdown and trim
    for (int k = 0; k < 8; k++) begin
      rnd = $urandom;
      ch1_in <= rnd[23:0];
      ch2_in <= ~rnd[23:0];
      cfg = $urandom;
      cfg[2:0] = k[2:0];
      cfg[5:3] = 3'h7 - k[2:0];
      host.write_word(cfg);
      do_read(rd);
      check_val(rd, cfg & 32'h00ff_03ff, "config readback");
      check_val({29'h0, g1}, {29'h0, exp_shift(k[2:0])}, "gain ch1");
      check_val({29'h0, g2}, {29'h0, exp_shift(3'h7 - k[2:0])}, "gain ch2");
      check_val({8'h0, ch1_out}, cfg[6] ? 32'h0 : {8'h0, ch1_in}, "sample ch1");
      check_val({8'h0, ch2_out}, cfg[7] ? 32'h0 : {8'h0, ch2_in}, "sample ch2");
      check_val({30'h0, conv_en}, {30'h0, ~cfg[9:8]}, "enables");
      check_val({24'h0, trim}, {24'h0, cfg[23:16]}, "trim");
    end
    $display("test configuration done");
    // live bits sampled at computation end, sticky bits set and cleared
    host.set_pointer(16'h0002);
    sticky = '0;
    for (int i = 0; i < 8; i++) begin
      rnd = $urandom;
      m   = pmscr_meas_t'(rnd[8:0]);
      ev  = (i == 7) ? 4'h0 : rnd[12:9];
      clr = (i >= 6) ? 4'hf : rnd[16:13];
      @(posedge clk_i);
      meas         <= m;
      compute_done <= 1'b1;
      event_s      <= pmscr_event_t'(ev);
      event_clr    <= pmscr_event_t'(clr);
      @(posedge clk_i);
      compute_done <= 1'b0;
      event_s      <= '0;
      event_clr    <= '0;
      meas         <= ~m;
      sticky = (sticky & ~clr) | ev;
      do_read(rd);
      check_val(rd, exp_status(m, sticky), "status word");
    end
    $display("test status flags done");
    tally_and_finish();
  end
endmodule : tb_power_monitor_status_config_regs
`default_nettype wire
